// >>> spbr_defs.svh
// Register offsets, field positions, reset values and timing counts of the serial port block.
`ifndef SPBR_DEFS_SVH
`define SPBR_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define SPBR_OFF_CTRL 8'h00
`define SPBR_OFF_STATUS 8'h04
`define SPBR_OFF_MASK 8'h08
`define SPBR_OFF_TXDATA 8'h0C
`define SPBR_OFF_RXDATA 8'h10
`define SPBR_OFF_INFO 8'h14

// ==========================================================================
// Control register field positions
`define SPBR_CTRL_SYNC 0
`define SPBR_CTRL_CLOCK_SOURCE_MASTER 1
`define SPBR_CTRL_SERIAL_PORT_ENABLE 2
`define SPBR_CTRL_SINGLE_RECEIVE_ENABLE 3
`define SPBR_CTRL_CONTINUOUS_RECEIVE_ENABLE 4
`define SPBR_CTRL_TRANSMIT_ENABLE_BIT 5
`define SPBR_CTRL_TX9 6
`define SPBR_CTRL_NINTH_TRANSMIT_BIT 7
`define SPBR_CTRL_WUE 8
`define SPBR_CTRL_AUTOBAUD_ENABLE 9
`define SPBR_CTRL_TRANSMIT_IRQ_ENABLE 10
`define SPBR_CTRL_PERIPHERAL_IRQ_GATE 11
`define SPBR_CTRL_GIE 12
`define SPBR_CTRL_RST 13'h0000

// ==========================================================================
// Event status and mask bit positions
`define SPBR_EV_RXRDY 0
`define SPBR_EV_BREAK 1
`define SPBR_EV_TXE 2
`define SPBR_EV_WAKE 3
`define SPBR_EV_RST 4'h0

// ==========================================================================
// Info register bit positions
`define SPBR_INFO_TRANSMIT_BUFFER_EMPTY_FLAG 0
`define SPBR_INFO_RECEIVE_READY_FLAG 1
`define SPBR_INFO_FRAMING_ERROR_FLAG 2
`define SPBR_INFO_BREAK 3
`define SPBR_INFO_BUSY 4

// ==========================================================================
// Timing
`define SPBR_BAUD_DIV 16

`endif

// >>> spbr_pkg.sv
// Types shared by the serial port block.
package spbr_pkg;

  typedef struct packed {
    logic global_interrupt_enable;
    logic peripheral_irq_gate;
    logic transmit_irq_enable;
    logic autobaud_enable;
    logic wue;
    logic ninth_transmit_bit;
    logic tx9;
    logic transmit_enable_bit;
    logic continuous_receive_enable;
    logic single_receive_enable;
    logic serial_port_enable;
    logic clock_source_master;
    logic sync_mode;
  } spbr_ctrl_t;

  typedef struct packed {
    logic ck;
    logic rxd;
  } spbr_pins_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } spbr_rx_state_t;

endpackage

// >>> spbr_sync.sv
// Two-flop synchroniser for the pin inputs.
`timescale 1ns/100ps
`default_nettype none
module spbr_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  if (W < 1)
  begin : g_bad_width
    $error("W must be at least 1");
  end

  // The first stage feeds only the second one.
  always_ff @(posedge clk_i)
  begin
    // Reset loads the idle levels of the pins, so no false edge follows reset.
    if (rst_i)
    begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // spbr_sync
`default_nettype wire

// >>> spbr_top.sv
// Serial port: Break reception, auto-wake-up and clocked slave transmission with a Wishbone register file.
// Operation
// [RULE1] Break is reported when receive-ready and framing error are set and data is zero.
// [RULE2] Auto-wake-up waits two line transitions, flags receive, then takes the next byte.
// [RULE3] Software may arm auto-baud after a Break, also before sleeping.
// [RULE4] Slave operation needs clocked mode, clock source master clear and port enabled.
// [RULE5] Slave transmits while both receive enables are clear, receives otherwise.
// [RULE6] Slave transmit matches master transmit apart from sleep behaviour.
// [RULE7] In sleep the first queued word loads the shift register at once.
// [RULE8] While the second word waits in the holding buffer, buffer-empty stays clear.
// [RULE9] After the first word leaves, the held word loads and buffer-empty sets.
// [RULE10] Buffer-empty with both enables wakes the core; global enable adds the ISR.
// [RULE11] Set-up order: mode, enable, slave, analog off, receive enables clear.
// [RULE12] Interrupt transmit needs transmit, global and peripheral enables set first.
// [RULE13] For nine bits set the ninth enable first, then the ninth bit.
// [RULE14] Set transmit enable, then write the low eight bits to start.
// [RULE15] Buffer-empty is set while transmit is enabled and nothing is held; read-only.
// [RULE16] Words move least significant bit first in both directions.
// [RULE17] The external master supplies every bit clock; one bit per clock.
`include "spbr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module spbr_top #(
  parameter int BAUD_DIV = `SPBR_BAUD_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic shift_timing_pin_i,
  input wire logic receive_data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe_o,
  input wire logic sleep_i,
  output logic break_o,
  output logic wake_o,
  output logic isr_req_o,
  output logic irq_o
);
  if (BAUD_DIV < 4 || BAUD_DIV > 65535)
  begin : g_bad_div
    $error("BAUD_DIV out of range");
  end

  localparam int CW = $clog2(BAUD_DIV) + 1;

  // ==========================================================================
  // Pin synchronisation and edge detection
  spbr_pkg::spbr_pins_t pins_s;
  spbr_pkg::spbr_pins_t pins_d;
  logic ck_rise;
  logic ck_fall;
  logic rxd_fall;
  logic rxd_edge;

  spbr_sync #(.W(2), .RST_VAL(2'h1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({shift_timing_pin_i, receive_data_pin_i}),
    .q_o(pins_s)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pins_d <= '{ck: 1'b0, rxd: 1'b1};
    else
      pins_d <= pins_s;
  end

  assign ck_rise = pins_s.ck & ~pins_d.ck;
  assign ck_fall = ~pins_s.ck & pins_d.ck;
  assign rxd_fall = ~pins_s.rxd & pins_d.rxd;
  assign rxd_edge = pins_s.rxd ^ pins_d.rxd;

  // ==========================================================================
  // Bus decode
  spbr_pkg::spbr_ctrl_t ctrl;
  logic req;
  logic wr;
  logic rd;
  logic [3:0] status;
  logic [3:0] mask;
  logic [3:0] ev_set;
  logic [7:0] rx_data;
  logic receive_ready_flag;
  logic framing_error_flag;
  logic wake_done;
  logic rx_done;
  logic next_framing_error_flag;
  logic [7:0] next_rx_data;
  logic [7:0] hold_data;
  logic hold_full;
  logic [8:0] transmit_shift_register;
  logic [3:0] tx_cnt;
  logic tx_busy;
  logic transmit_buffer_empty_flag;
  logic transmit_buffer_empty_flag_d;
  logic tx_load;
  logic slave_mode;
  logic tx_mode;
  logic rx_sync_mode;
  logic rx_async_mode;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write lands at the edge where the master sees ack high, so it takes effect exactly once.
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (rd)
    begin
      unique case (wb_adr_i)
        `SPBR_OFF_CTRL: wb_dat_o <= {19'h00000, ctrl};
        `SPBR_OFF_STATUS: wb_dat_o <= {28'h0000000, status};
        `SPBR_OFF_MASK: wb_dat_o <= {28'h0000000, mask};
        `SPBR_OFF_RXDATA: wb_dat_o <= {24'h000000, rx_data};
        `SPBR_OFF_INFO: wb_dat_o <= {27'h0000000, tx_busy, break_o, framing_error_flag, receive_ready_flag, transmit_buffer_empty_flag};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Control register
  // Hardware clears the wake-up enable once the two transitions are seen; a software write wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= spbr_pkg::spbr_ctrl_t'(`SPBR_CTRL_RST);
    else if (wr && wb_adr_i == `SPBR_OFF_CTRL)
    begin
      ctrl.sync_mode <= wb_dat_i[`SPBR_CTRL_SYNC];
      ctrl.clock_source_master <= wb_dat_i[`SPBR_CTRL_CLOCK_SOURCE_MASTER];
      ctrl.serial_port_enable <= wb_dat_i[`SPBR_CTRL_SERIAL_PORT_ENABLE];
      ctrl.single_receive_enable <= wb_dat_i[`SPBR_CTRL_SINGLE_RECEIVE_ENABLE];
      ctrl.continuous_receive_enable <= wb_dat_i[`SPBR_CTRL_CONTINUOUS_RECEIVE_ENABLE];
      ctrl.transmit_enable_bit <= wb_dat_i[`SPBR_CTRL_TRANSMIT_ENABLE_BIT];
      ctrl.tx9 <= wb_dat_i[`SPBR_CTRL_TX9];
      ctrl.ninth_transmit_bit <= wb_dat_i[`SPBR_CTRL_NINTH_TRANSMIT_BIT];
      ctrl.wue <= wb_dat_i[`SPBR_CTRL_WUE];
      ctrl.autobaud_enable <= wb_dat_i[`SPBR_CTRL_AUTOBAUD_ENABLE];
      ctrl.transmit_irq_enable <= wb_dat_i[`SPBR_CTRL_TRANSMIT_IRQ_ENABLE];
      ctrl.peripheral_irq_gate <= wb_dat_i[`SPBR_CTRL_PERIPHERAL_IRQ_GATE];
      ctrl.global_interrupt_enable <= wb_dat_i[`SPBR_CTRL_GIE];
    end
    else if (wake_done)
      ctrl.wue <= 1'b0;
  end

  // ==========================================================================
  // Mode selection
  // The auto-baud enable is only stored; rate measurement lives outside this block.
  assign slave_mode = ctrl.serial_port_enable & ctrl.sync_mode & ~ctrl.clock_source_master; // RULE4
  assign tx_mode = slave_mode & ~ctrl.single_receive_enable & ~ctrl.continuous_receive_enable; // RULE5
  assign rx_sync_mode = slave_mode & (ctrl.single_receive_enable | ctrl.continuous_receive_enable); // RULE5
  assign rx_async_mode = ctrl.serial_port_enable & ~ctrl.sync_mode & ctrl.continuous_receive_enable;
  assign data_pin_oe_o = tx_mode;

  // ==========================================================================
  // Receiver: asynchronous frames, clocked slave frames and auto-wake-up
  spbr_pkg::spbr_rx_state_t rx_state;
  logic [CW-1:0] rx_tmr;
  logic [3:0] rx_bits;
  logic [7:0] rx_shift;
  logic wake_seen;

  // Wake-up needs two line transitions of either direction; no asynchronous frame is started meanwhile.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_seen <= 1'b0;
    else if (!ctrl.wue || wake_done)
      wake_seen <= 1'b0;
    else if (rxd_edge)
      wake_seen <= 1'b1;
  end

  assign wake_done = ctrl.wue & ctrl.serial_port_enable & wake_seen & rxd_edge; // RULE2

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_state <= spbr_pkg::RX_IDLE;
      rx_tmr <= '0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      next_framing_error_flag <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (rx_sync_mode)
      begin
        rx_state <= spbr_pkg::RX_IDLE;
        next_framing_error_flag <= 1'b0;
        if (ck_rise)
        begin
          rx_shift <= {pins_s.rxd, rx_shift[7:1]}; // RULE16
          rx_bits <= (rx_bits == 4'h7) ? 4'h0 : rx_bits + 4'h1;
          rx_done <= (rx_bits == 4'h7);
        end
      end
      else
      begin
        unique case (rx_state)
          spbr_pkg::RX_IDLE:
          begin
            rx_bits <= 4'h0;
            if (rx_async_mode && !ctrl.wue && rxd_fall)
            begin
              rx_state <= spbr_pkg::RX_START;
              // The synchroniser already delays the start, so one cycle less keeps the sample mid-bit.
              rx_tmr <= CW'(BAUD_DIV / 2 - 1);
            end
          end
          spbr_pkg::RX_START:
          begin
            if (rx_tmr != '0)
              rx_tmr <= rx_tmr - CW'(1);
            else if (!pins_s.rxd)
            begin
              rx_state <= spbr_pkg::RX_DATA;
              rx_tmr <= CW'(BAUD_DIV - 1);
            end
            else
              rx_state <= spbr_pkg::RX_IDLE;
          end
          spbr_pkg::RX_DATA:
          begin
            if (rx_tmr != '0)
              rx_tmr <= rx_tmr - CW'(1);
            else
            begin
              rx_shift <= {pins_s.rxd, rx_shift[7:1]}; // RULE16
              rx_bits <= rx_bits + 4'h1;
              rx_tmr <= CW'(BAUD_DIV - 1);
              if (rx_bits == 4'h7)
                rx_state <= spbr_pkg::RX_STOP;
            end
          end
          spbr_pkg::RX_STOP:
          begin
            if (rx_tmr != '0)
              rx_tmr <= rx_tmr - CW'(1);
            else
            begin
              // A low stop bit after all-zero data is how a Break shows up.
              next_framing_error_flag <= ~pins_s.rxd;
              rx_done <= 1'b1;
              rx_state <= spbr_pkg::RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign next_rx_data = rx_shift;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_data <= 8'h00;
      framing_error_flag <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_data <= next_rx_data;
      framing_error_flag <= next_framing_error_flag;
    end
  end

  // A new byte or a completed wake-up sets the flag even in the cycle that a read clears it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      receive_ready_flag <= 1'b0;
    else if (rx_done || wake_done)
      receive_ready_flag <= 1'b1; // RULE2
    else if (rd && wb_adr_i == `SPBR_OFF_RXDATA)
      receive_ready_flag <= 1'b0;
  end

  assign break_o = receive_ready_flag & framing_error_flag & (rx_data == 8'h00); // RULE1

  // ==========================================================================
  // Slave transmitter
  // The bit clock comes from the master, so shifting carries on through sleep.
  assign tx_load = tx_mode & ctrl.transmit_enable_bit & hold_full & ~tx_busy; // RULE7 RULE9
  assign transmit_buffer_empty_flag = ctrl.transmit_enable_bit & ~hold_full; // RULE15 RULE8

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_data <= 8'h00;
      hold_full <= 1'b0;
    end
    else if (wr && wb_adr_i == `SPBR_OFF_TXDATA)
    begin
      hold_data <= wb_dat_i[7:0];
      hold_full <= 1'b1;
    end
    else if (tx_load)
      hold_full <= 1'b0; // RULE9
  end

  // One bit per external clock: a bit changes on the falling edge, the master samples on the rise.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      transmit_shift_register <= 9'h000;
      tx_cnt <= 4'h0;
      tx_busy <= 1'b0;
      data_pin_o <= 1'b1;
    end
    else if (!tx_mode)
    begin
      tx_busy <= 1'b0;
      tx_cnt <= 4'h0;
    end
    else if (tx_load)
    begin
      transmit_shift_register <= {ctrl.ninth_transmit_bit, hold_data}; // RULE6
      tx_cnt <= ctrl.tx9 ? 4'h9 : 4'h8;
      tx_busy <= 1'b1;
      data_pin_o <= hold_data[0]; // RULE16
    end
    else if (tx_busy && ck_fall)
    begin
      if (tx_cnt == 4'h1)
        tx_busy <= 1'b0;
      else
      begin
        transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
        data_pin_o <= transmit_shift_register[1]; // RULE17
        tx_cnt <= tx_cnt - 4'h1;
      end
    end
  end

  // ==========================================================================
  // Sleep wake-up and interrupt events
  assign wake_o = sleep_i & ctrl.peripheral_irq_gate & ctrl.transmit_irq_enable & transmit_buffer_empty_flag; // RULE10
  assign isr_req_o = ctrl.global_interrupt_enable & ctrl.peripheral_irq_gate & ctrl.transmit_irq_enable & transmit_buffer_empty_flag; // RULE10

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      transmit_buffer_empty_flag_d <= 1'b0;
    else
      transmit_buffer_empty_flag_d <= transmit_buffer_empty_flag;
  end

  always_comb
  begin
    ev_set = 4'h0;
    ev_set[`SPBR_EV_RXRDY] = rx_done;
    ev_set[`SPBR_EV_BREAK] = rx_done & next_framing_error_flag & (next_rx_data == 8'h00); // RULE1
    ev_set[`SPBR_EV_TXE] = transmit_buffer_empty_flag & ~transmit_buffer_empty_flag_d;
    ev_set[`SPBR_EV_WAKE] = wake_done;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= `SPBR_EV_RST;
    else if (rd && wb_adr_i == `SPBR_OFF_STATUS)
      status <= ev_set;
    else
      status <= status | ev_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask <= `SPBR_EV_RST;
    else if (wr && wb_adr_i == `SPBR_OFF_MASK)
      mask <= wb_dat_i[3:0];
  end

  assign irq_o = |(status & mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_break_report: assert property (rx_done && next_framing_error_flag && next_rx_data == 8'h00 |=> break_o) // RULE1
    else $error("break not reported");
  a_wake_flag: assert property (wake_done |=> receive_ready_flag && !ctrl.wue) // RULE2
    else $error("wake-up did not flag receive");
  a_rx_no_drive: assert property (rx_sync_mode |-> !data_pin_oe_o) // RULE5
    else $error("pin driven in receive mode");
  a_load_at_once: assert property (tx_load |=> tx_busy && !hold_full) // RULE7
    else $error("first word not loaded");
  a_held_keeps_clear: assert property (hold_full && tx_busy && !tx_load |-> !transmit_buffer_empty_flag) // RULE8
    else $error("buffer-empty set while word held");
  a_held_moves_on: assert property (tx_mode && tx_busy && ck_fall && tx_cnt == 4'h1 && hold_full && ctrl.transmit_enable_bit
    |=> ##1 tx_busy && transmit_buffer_empty_flag) // RULE9
    else $error("held word not moved");
  a_wake_request: assert property ($rose(transmit_buffer_empty_flag) && sleep_i && ctrl.peripheral_irq_gate && ctrl.transmit_irq_enable |-> wake_o) // RULE10
    else $error("no wake request");
  a_write_clears_empty: assert property (wr && wb_adr_i == `SPBR_OFF_TXDATA && tx_busy && ctrl.transmit_enable_bit
    && !(ck_fall && tx_cnt == 4'h1) |=> !transmit_buffer_empty_flag) // RULE15
    else $error("buffer-empty not cleared by write");
  a_lsb_first: assert property (tx_load |=> data_pin_o == $past(hold_data[0])) // RULE16
    else $error("first bit is not the least significant");

  c_break_seen: cover property (break_o);
  c_wake_seen: cover property (wake_done ##[1:400] rx_done);
  c_sleep_queue: cover property (sleep_i && tx_busy && hold_full ##[1:400] tx_load);
  c_nine_bit: cover property (tx_load && ctrl.tx9);
endmodule // spbr_top
`default_nettype wire

// >>> spbr_link_model.sv
// Behavioural far-side model: synchronous master clocking the slave and line driver for the receive pin.
`timescale 1ns/100ps
`default_nettype none
module spbr_link_model (
  input wire logic data_i,
  output logic ck_o,
  output logic rxd_o
);
  // ==========================================================================
  // Pin idle levels
  // The clock stands low between words; the receive line idles at the mark level.
  initial
  begin
    ck_o = 1'b0;
    rxd_o = 1'b1;
  end

  // ==========================================================================
  // Synchronous master: one 800 ns clock per bit, sampled on the rising edge
  // Every transfer starts 20 ns after the bench's clock edge, so no pin moves at a sampling edge.
  task automatic clock_word(input int n, output logic [8:0] w);
    w = 9'h000;
    #20;
    for (int i = 0; i < n; i++)
    begin
      ck_o = 1'b1;
      w[i] = data_i;
      #400;
      ck_o = 1'b0;
      #400;
    end
  endtask

  // Slave receive: data is set up half a bit before each rising clock edge.
  task automatic clock_in(input logic [7:0] b);
    #20;
    for (int i = 0; i < 8; i++)
    begin
      rxd_o = b[i];
      #400;
      ck_o = 1'b1;
      #400;
      ck_o = 1'b0;
    end
    rxd_o = 1'b1;
  endtask

  // ==========================================================================
  // Asynchronous frame: start, eight data bits, chosen stop level
  task automatic send_frame(input logic [7:0] b, input logic stop, input int bit_ns);
    #20;
    rxd_o = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++)
    begin
      rxd_o = b[i];
      #(bit_ns);
    end
    rxd_o = stop;
    #(bit_ns);
    rxd_o = 1'b1;
    #(bit_ns);
  endtask

  // Two line transitions 300 ns apart; the wake-up enable keeps them from being taken as a frame.
  task automatic wake_pulse();
    #20;
    rxd_o = 1'b0;
    #300;
    rxd_o = 1'b1;
  endtask
endmodule // spbr_link_model
`default_nettype wire

// >>> spbr_top_bench.sv
// Self-checking bench for the serial port block.
`include "spbr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module spbr_top_bench;
  localparam int BAUD_DIV = 4;
  localparam int BIT_NS = BAUD_DIV * 100;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ck;
  logic rxd;
  logic data_pin_o;
  logic data_pin_oe_o;
  logic sleep = 1'b0;
  logic break_o;
  logic wake_o;
  logic isr_req_o;
  logic irq_o;
  int err_count = 0;
  int compares = 0;

  always #50 clk_i = ~clk_i;

  spbr_top #(.BAUD_DIV(BAUD_DIV)) spbr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .shift_timing_pin_i(ck), .receive_data_pin_i(rxd), .data_pin_o(data_pin_o),
    .data_pin_oe_o(data_pin_oe_o), .sleep_i(sleep), .break_o(break_o), .wake_o(wake_o),
    .isr_req_o(isr_req_o), .irq_o(irq_o));

  spbr_link_model spbr_link_model_i (.data_i(data_pin_o), .ck_o(ck), .rxd_o(rxd));

  // ==========================================================================
  // Shared tasks
  task automatic finish_test();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] bitv(input int p);
    return 32'h00000001 << p;
  endfunction

  // Classic single cycle; the wait is bounded so a silent slave cannot hang the run.
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1);
  endtask

  // The write lands at the ack edge; one more edge lets its effects settle before callers look.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(`SPBR_OFF_CTRL, 32'h00000000);
    rd_chk(`SPBR_OFF_STATUS, 32'h00000000);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00000000);
    chk(irq_o, 1'b0);
  endtask

  task automatic t_break();
    wr(`SPBR_OFF_CTRL, bitv(`SPBR_CTRL_SERIAL_PORT_ENABLE) | bitv(`SPBR_CTRL_CONTINUOUS_RECEIVE_ENABLE));
    wr(`SPBR_OFF_MASK, bitv(`SPBR_EV_BREAK));
    spbr_link_model_i.send_frame(8'hA5, 1'b1, BIT_NS);
    rd_chk(`SPBR_OFF_RXDATA, 32'h000000A5);
    chk(break_o, 1'b0);
    spbr_link_model_i.send_frame(8'h00, 1'b0, BIT_NS);
    chk(break_o, 1'b1);
    chk(irq_o, 1'b1);
    rd_chk(`SPBR_OFF_INFO, bitv(`SPBR_INFO_RECEIVE_READY_FLAG) | bitv(`SPBR_INFO_FRAMING_ERROR_FLAG) | bitv(`SPBR_INFO_BREAK));
    rd_chk(`SPBR_OFF_STATUS, bitv(`SPBR_EV_RXRDY) | bitv(`SPBR_EV_BREAK));
    rd_chk(`SPBR_OFF_STATUS, 32'h00000000);
    chk(irq_o, 1'b0);
    rd_chk(`SPBR_OFF_RXDATA, 32'h00000000);
    chk(break_o, 1'b0);
    wr(`SPBR_OFF_CTRL, bitv(`SPBR_CTRL_SERIAL_PORT_ENABLE) | bitv(`SPBR_CTRL_CONTINUOUS_RECEIVE_ENABLE) | bitv(`SPBR_CTRL_AUTOBAUD_ENABLE));
    rd_chk(`SPBR_OFF_CTRL, bitv(`SPBR_CTRL_SERIAL_PORT_ENABLE) | bitv(`SPBR_CTRL_CONTINUOUS_RECEIVE_ENABLE) | bitv(`SPBR_CTRL_AUTOBAUD_ENABLE));
  endtask

  task automatic t_wake();
    wr(`SPBR_OFF_MASK, bitv(`SPBR_EV_WAKE));
    wr(`SPBR_OFF_CTRL, bitv(`SPBR_CTRL_SERIAL_PORT_ENABLE) | bitv(`SPBR_CTRL_CONTINUOUS_RECEIVE_ENABLE) | bitv(`SPBR_CTRL_WUE));
    spbr_link_model_i.wake_pulse();
    #(BIT_NS * 2);
    chk(irq_o, 1'b1);
    // The zero byte and framing error of the break frame still stand, so the wake-up reads as a Break.
    rd_chk(`SPBR_OFF_INFO, bitv(`SPBR_INFO_RECEIVE_READY_FLAG) | bitv(`SPBR_INFO_FRAMING_ERROR_FLAG) | bitv(`SPBR_INFO_BREAK));
    rd_chk(`SPBR_OFF_RXDATA, 32'h00000000);
    spbr_link_model_i.send_frame(8'h3C, 1'b1, BIT_NS);
    rd_chk(`SPBR_OFF_RXDATA, 32'h0000003C);
  endtask

  task automatic t_slave_tx();
    logic [8:0] w;
    logic [31:0] c;
    c = bitv(`SPBR_CTRL_SYNC) | bitv(`SPBR_CTRL_SERIAL_PORT_ENABLE);
    wr(`SPBR_OFF_CTRL, c);
    c = c | bitv(`SPBR_CTRL_TRANSMIT_IRQ_ENABLE) | bitv(`SPBR_CTRL_PERIPHERAL_IRQ_GATE);
    wr(`SPBR_OFF_CTRL, c);
    c = c | bitv(`SPBR_CTRL_TRANSMIT_ENABLE_BIT);
    wr(`SPBR_OFF_CTRL, c);
    rd_chk(`SPBR_OFF_INFO, bitv(`SPBR_INFO_TRANSMIT_BUFFER_EMPTY_FLAG));
    chk(data_pin_oe_o, 1'b1);
    @(posedge clk_i);
    sleep <= 1'b1;
    wr(`SPBR_OFF_TXDATA, 32'h0000005A);
    wr(`SPBR_OFF_TXDATA, 32'h000000C3);
    rd_chk(`SPBR_OFF_INFO, bitv(`SPBR_INFO_BUSY));
    chk(wake_o, 1'b0);
    spbr_link_model_i.clock_word(8, w);
    chk(w, 32'h0000005A);
    repeat (6) @(posedge clk_i);
    rd_chk(`SPBR_OFF_INFO, bitv(`SPBR_INFO_BUSY) | bitv(`SPBR_INFO_TRANSMIT_BUFFER_EMPTY_FLAG));
    chk(wake_o, 1'b1);
    chk(isr_req_o, 1'b0);
    wr(`SPBR_OFF_CTRL, c | bitv(`SPBR_CTRL_GIE));
    chk(isr_req_o, 1'b1);
    spbr_link_model_i.clock_word(8, w);
    chk(w, 32'h000000C3);
    @(posedge clk_i);
    sleep <= 1'b0;
    c = c & ~bitv(`SPBR_CTRL_TRANSMIT_ENABLE_BIT);
    wr(`SPBR_OFF_CTRL, c | bitv(`SPBR_CTRL_TX9));
    c = c | bitv(`SPBR_CTRL_TX9) | bitv(`SPBR_CTRL_TRANSMIT_ENABLE_BIT);
    wr(`SPBR_OFF_CTRL, c);
    wr(`SPBR_OFF_CTRL, c | bitv(`SPBR_CTRL_NINTH_TRANSMIT_BIT));
    wr(`SPBR_OFF_TXDATA, 32'h00000096);
    spbr_link_model_i.clock_word(9, w);
    chk(w, 32'h00000196);
    wr(`SPBR_OFF_CTRL, c | bitv(`SPBR_CTRL_SINGLE_RECEIVE_ENABLE));
    chk(data_pin_oe_o, 1'b0);
    spbr_link_model_i.clock_in(8'h4B);
    rd_chk(`SPBR_OFF_RXDATA, 32'h0000004B);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_break();
    t_wake();
    t_slave_tx();
    finish_test();
  end

  initial
  begin
    #2000000;
    err_count++;
    finish_test();
  end
endmodule // spbr_top_bench
`default_nettype wire
